// >>> verilog/vofr_pkg.sv
// Constants, field layout and state encoding for the per-channel
// output over/undervoltage fault response block.
// Assumes a 100 MHz core clock shared by all users of this package.
package vofr_pkg;

    // Core clock period
    localparam int CLK_PERIOD_NS = 10;

    // Supervisor sample period and its length in clock cycles
    localparam int SAMPLE_PERIOD_NS = 12200;
    localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    // Turn-off delay is counted in 10 us units
    localparam int TOFF_UNIT_NS     = 10000;
    localparam int TOFF_UNIT_CYCLES = TOFF_UNIT_NS / CLK_PERIOD_NS;

    // Ceiling on the effective turn-off delay, in ms and in units
    localparam int TOFF_CAP_MS      = 13100;
    localparam logic [20:0] TOFF_CAP_UNITS =
        21'(TOFF_CAP_MS * 1000 / (TOFF_UNIT_NS / 1000));

    // Response setting field positions
    localparam int ACT_HI   = 7;
    localparam int ACT_LO   = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DLY_HI   = 2;
    localparam int DLY_LO   = 0;

    // Response setting reset values
    localparam logic [7:0] OV_CFG_RESET = 8'h00;
    localparam logic [7:0] UV_CFG_RESET = 8'h00;

    // Response action codes
    localparam logic [1:0] ACT_CONTINUE = 2'h0;
    localparam logic [1:0] ACT_DEGLITCH = 2'h1;

    // Channel states, Gray coded along run, deglitch, turn-off, off
    typedef enum logic [1:0] {
        ST_RUN      = 2'h0,
        ST_DEGLITCH = 2'h1,
        ST_TOFF     = 2'h3,
        ST_OFF      = 2'h2
    } vofr_state_e;

endpackage : vofr_pkg

// >>> verilog/vofr_fault_response.sv
// One channel of output over/undervoltage fault response: sampling,
// deglitch, shutdown, turn-off delay, restart, status and alert.
// Assumes all inputs are synchronous to clk and that the host side
// delivers response-setting writes as single-cycle strobes.
//
// What this block does
// (R1) Action zero keeps channel running on fault
// (R2) Action one waits delay field times sample period
// (R3) Action one shuts down only if fault persists
// (R4) Action upper bit set shuts down without wait
// (R5) Mode selects immediate or sequenced turn-off
// (R6) Retry field sets restart policy after shutdown
// (R7) Retry zero holds output off until cleared
// (R8) Nonzero retry restarts up to global limit
// (R9) Off command or other fault stops restarts
// (R10) Action one delay zero turns channel off immediately
// (R11) Action one nonzero delay ignores fault that many samples
// (R12) Fault sets summary byte and word bits
// (R13) Fault sets channel voltage status bit
// (R14) Fault pulls active-low host alert line
// (R15) Current-mode odd channel ignores voltage faults
// (R16) Sequenced turn-off disables after turn-off delay
// (R17) Effective turn-off delay capped at 13.1 s
// (R18) Sample above/below fault limit flags fault
`timescale 1ns/1ns
module vofr_fault_response
(
    input  wire logic        clk,              // Core clock
    input  wire logic        rst,              // Async reset, high
    input  wire logic [15:0] sampleVoltage,    // Supervisor reading
    input  wire logic [15:0] ovFaultLimit,     // Overvoltage limit
    input  wire logic [15:0] uvFaultLimit,     // Undervoltage limit
    input  wire logic        cfgWrite,         // Setting write strobe
    input  wire logic        cfgSelUv,         // 1 selects UV setting
    input  wire logic [7:0]  cfgData,          // Setting write data
    input  wire logic [2:0]  retryLimit,       // Global retry count
    input  wire logic        sequencedOff,     // 1 uses turn-off delay
    input  wire logic [20:0] toffDelay,        // Turn-off delay, 10 us
    input  wire logic        channelOn,        // Pin and command on
    input  wire logic        otherFault,       // Other fault shutdown
    input  wire logic        currentMode,      // Odd channel in I mode
    input  wire logic        faultClear,       // Clears latched off
    input  wire logic        statusClear,      // Clears status bits
    output logic [7:0]       ovResponseCfg,    // OV setting readback
    output logic [7:0]       uvResponseCfg,    // UV setting readback
    output logic             channelEnable,    // Converter enable
    output logic             statusVoutOv,     // Channel OV status
    output logic             statusVoutUv,     // Channel UV status
    output logic             statusByteVout,   // Summary byte bit
    output logic             statusWordVout,   // Summary word bit
    output logic             hostAlertLineOut, // Alert pin level
    output logic             hostAlertLineOe   // High while pulling
);

    // Action field of a response setting
    function automatic logic [1:0] fieldAction(input logic [7:0] c);
        fieldAction = c[vofr_pkg::ACT_HI:vofr_pkg::ACT_LO];
    endfunction : fieldAction
    // Retry field of a response setting
    function automatic logic [2:0] fieldRetry(input logic [7:0] c);
        fieldRetry = c[vofr_pkg::RETRY_HI:vofr_pkg::RETRY_LO];
    endfunction : fieldRetry
    // Deglitch sample count of a response setting
    function automatic logic [2:0] fieldDelay(input logic [7:0] c);
        fieldDelay = c[vofr_pkg::DLY_HI:vofr_pkg::DLY_LO];
    endfunction : fieldDelay

    // Response setting registers
    logic [7:0]  next_ovResponseCfg;
    logic [7:0]  next_uvResponseCfg;
    // Sample timer
    logic [10:0] sampleTimer;          // Cycles into sample period
    logic [10:0] next_sampleTimer;
    logic        sampleTick;           // One cycle per sample
    // Detection of this sample
    logic        ovNow;                // OV seen on this sample
    logic        uvNow;                // UV seen on this sample
    logic        anyNow;               // Either fault this sample
    // Channel state
    vofr_pkg::vofr_state_e state;
    vofr_pkg::vofr_state_e next_state;
    logic        kindOv;               // Latched fault was OV
    logic        next_kindOv;
    logic [2:0]  degCount;             // Samples left to deglitch
    logic [2:0]  next_degCount;
    logic [20:0] toffUnits;            // Elapsed turn-off units
    logic [20:0] next_toffUnits;
    logic [9:0]  toffPre;              // Cycles into one unit
    logic [9:0]  next_toffPre;
    logic [2:0]  retryCount;           // Restarts made so far
    logic [2:0]  next_retryCount;
    logic        retryStop;            // Restarts barred
    logic        next_retryStop;
    logic        next_channelEnable;
    // Status bits
    logic        next_statusVoutOv;
    logic        next_statusVoutUv;

    // Helper terms
    logic [7:0]  newCfg;               // Setting of the new fault
    logic [7:0]  heldCfg;              // Setting of latched fault
    logic        heldNow;              // Latched kind present now
    logic [20:0] toffEff;              // Capped turn-off delay

    // Setting register update; a write strobe picks one setting
    always_comb
    begin
        next_ovResponseCfg = (cfgWrite && !cfgSelUv) ? cfgData
                                                     : ovResponseCfg;
        next_uvResponseCfg = (cfgWrite && cfgSelUv) ? cfgData
                                                    : uvResponseCfg;
    end
    // Setting registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ovResponseCfg <= vofr_pkg::OV_CFG_RESET;
            uvResponseCfg <= vofr_pkg::UV_CFG_RESET;
        end
        else
        begin
            ovResponseCfg <= next_ovResponseCfg;
            uvResponseCfg <= next_uvResponseCfg;
        end
    end

    // Sample period divider
    always_comb
    begin
        sampleTick = sampleTimer == 11'(vofr_pkg::SAMPLE_CYCLES - 1);
        next_sampleTimer = sampleTick ? 11'h000 : sampleTimer + 11'h001;
    end
    // Sample timer register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sampleTimer <= 11'h000;
        end
        else
        begin
            sampleTimer <= next_sampleTimer;
        end
    end

    // Limit comparison on each sample, masked in current mode
    always_comb
    begin
        ovNow  = sampleTick && !currentMode &&
                 (sampleVoltage > ovFaultLimit);    // R18 R15
        uvNow  = sampleTick && !currentMode &&
                 (sampleVoltage < uvFaultLimit);    // R18 R15
        anyNow = ovNow || uvNow;
    end
    // Setting selection and turn-off ceiling
    always_comb
    begin
        newCfg  = ovNow ? ovResponseCfg : uvResponseCfg;
        heldCfg = kindOv ? ovResponseCfg : uvResponseCfg;
        heldNow = kindOv ? ovNow : uvNow;
        toffEff = (toffDelay > vofr_pkg::TOFF_CAP_UNITS) ?
                  vofr_pkg::TOFF_CAP_UNITS : toffDelay;     // R17
    end

    // Channel state next values
    always_comb
    begin
        next_state      = state;
        next_kindOv     = kindOv;
        next_degCount   = degCount;
        next_toffUnits  = toffUnits;
        next_toffPre    = toffPre;
        next_retryCount = retryCount;
        next_retryStop  = retryStop;
        unique case (state)
            // Running: judge a new fault by its action field
            vofr_pkg::ST_RUN:
            begin
                if (anyNow &&
                    fieldAction(newCfg) != vofr_pkg::ACT_CONTINUE) // R1
                begin
                    next_kindOv = ovNow;
                    if (fieldAction(newCfg) == vofr_pkg::ACT_DEGLITCH &&
                        fieldDelay(newCfg) != 3'h0)
                    begin
                        // Wait out the deglitch samples
                        next_state    = vofr_pkg::ST_DEGLITCH;   // R2
                        next_degCount = fieldDelay(newCfg);      // R11
                    end
                    else if (sequencedOff)
                    begin
                        // Upper bit or zero delay: no wait
                        next_state     = vofr_pkg::ST_TOFF;  // R4 R10 R5
                        next_toffUnits = 21'h000000;
                        next_toffPre   = 10'h000;
                    end
                    else
                    begin
                        next_state = vofr_pkg::ST_OFF;       // R4 R10 R5
                    end
                end
            end
            // Deglitch: count samples, then check persistence
            vofr_pkg::ST_DEGLITCH:
            begin
                if (sampleTick)
                begin
                    if (degCount != 3'h1)
                    begin
                        next_degCount = degCount - 3'h1;         // R11
                    end
                    else if (!heldNow)
                    begin
                        next_state = vofr_pkg::ST_RUN;           // R3
                    end
                    else if (sequencedOff)
                    begin
                        next_state     = vofr_pkg::ST_TOFF;      // R3 R5
                        next_toffUnits = 21'h000000;
                        next_toffPre   = 10'h000;
                    end
                    else
                    begin
                        next_state = vofr_pkg::ST_OFF;           // R3 R5
                    end
                end
            end
            // Sequenced turn-off: enable stays on for the delay
            vofr_pkg::ST_TOFF:
            begin
                if (toffUnits >= toffEff)
                begin
                    next_state = vofr_pkg::ST_OFF;               // R16
                end
                else if (toffPre ==
                         10'(vofr_pkg::TOFF_UNIT_CYCLES - 1))
                begin
                    next_toffPre   = 10'h000;
                    next_toffUnits = toffUnits + 21'h000001;
                end
                else
                begin
                    next_toffPre = toffPre + 10'h001;
                end
            end
            // Off: wait for a clear or a permitted restart
            vofr_pkg::ST_OFF:
            begin
                if (!channelOn || otherFault)
                begin
                    next_retryStop = 1'b1;                       // R9
                end
                if (faultClear)
                begin
                    next_state      = vofr_pkg::ST_RUN;          // R7
                    next_retryCount = 3'h0;
                    next_retryStop  = 1'b0;
                end
                else if (fieldRetry(heldCfg) != 3'h0 &&      // R6 R7
                         !retryStop && channelOn && !otherFault &&
                         retryCount < retryLimit &&             // R8
                         sampleTick && !anyNow)
                begin
                    next_state      = vofr_pkg::ST_RUN;          // R8
                    next_retryCount = retryCount + 3'h1;
                end
            end
        endcase
        // Converter enable follows the commanded state
        next_channelEnable = channelOn &&
                             (next_state != vofr_pkg::ST_OFF);
        // Sticky status; a new fault wins over a clear
        next_statusVoutOv = (statusVoutOv && !statusClear) || ovNow; // R13
        next_statusVoutUv = (statusVoutUv && !statusClear) || uvNow; // R13
    end

    // Channel state registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state         <= vofr_pkg::ST_RUN;
            kindOv        <= 1'b0;
            degCount      <= 3'h0;
            toffUnits     <= 21'h000000;
            toffPre       <= 10'h000;
            retryCount    <= 3'h0;
            retryStop     <= 1'b0;
            channelEnable <= 1'b0;
            statusVoutOv  <= 1'b0;
            statusVoutUv  <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            kindOv        <= next_kindOv;
            degCount      <= next_degCount;
            toffUnits     <= next_toffUnits;
            toffPre       <= next_toffPre;
            retryCount    <= next_retryCount;
            retryStop     <= next_retryStop;
            channelEnable <= next_channelEnable;
            statusVoutOv  <= next_statusVoutOv;
            statusVoutUv  <= next_statusVoutUv;
        end
    end

    // Summary bits and open-drain alert, any action code
    assign statusByteVout   = statusVoutOv || statusVoutUv;   // R12
    assign statusWordVout   = statusVoutOv || statusVoutUv;   // R12
    assign hostAlertLineOut = 1'b0;                           // R14
    assign hostAlertLineOe  = statusVoutOv || statusVoutUv;   // R14

    // A new fault seen while running
    sequence sRunFault;
        state == vofr_pkg::ST_RUN && anyNow;
    endsequence

    // Deglitch window closing on its last sample
    sequence sDegEnd;
        state == vofr_pkg::ST_DEGLITCH && sampleTick && degCount == 3'h1;
    endsequence

    AST_CONTINUE: assert property (@(posedge clk) disable iff (rst) // R1
        sRunFault ##0 fieldAction(newCfg) == vofr_pkg::ACT_CONTINUE
        |=> state == vofr_pkg::ST_RUN)
        else $error("continue action left run state");
    AST_DEGLITCH: assert property (@(posedge clk) disable iff (rst) // R2
        sRunFault ##0 fieldAction(newCfg) == vofr_pkg::ACT_DEGLITCH
        ##0 fieldDelay(newCfg) != 3'h0
        |=> state == vofr_pkg::ST_DEGLITCH
            && degCount == fieldDelay($past(newCfg)))
        else $error("deglitch not entered with delay count");
    AST_PERSIST: assert property (@(posedge clk) disable iff (rst) // R3
        sDegEnd ##0 !heldNow |=> state == vofr_pkg::ST_RUN)
        else $error("cleared fault still shut channel");
    AST_IMMEDIATE: assert property (@(posedge clk) disable iff (rst) // R4
        sRunFault ##0 newCfg[vofr_pkg::ACT_HI] ##0 !sequencedOff
        |=> state == vofr_pkg::ST_OFF ##1 !channelEnable)
        else $error("upper action bit did not shut down");
    AST_SEQUENCED: assert property (@(posedge clk) disable iff (rst) // R5
        sRunFault ##0 newCfg[vofr_pkg::ACT_HI] ##0 sequencedOff
        |=> state == vofr_pkg::ST_TOFF && toffUnits == 21'h000000)
        else $error("sequenced mode skipped turn-off delay");
    AST_NO_RETRY: assert property (@(posedge clk) disable iff (rst) // R7
        state == vofr_pkg::ST_OFF && fieldRetry(heldCfg) == 3'h0
        && !faultClear |=> state == vofr_pkg::ST_OFF)
        else $error("restart with zero retry field");
    AST_TOFF_HOLD: assert property (@(posedge clk) disable iff (rst) // R16
        state == vofr_pkg::ST_TOFF && toffUnits < toffEff
        |=> state != vofr_pkg::ST_OFF)
        else $error("turn-off before delay elapsed");
    AST_TOFF_CAP: assert property (@(posedge clk) disable iff (rst) // R17
        state == vofr_pkg::ST_TOFF |-> toffUnits <= vofr_pkg::TOFF_CAP_UNITS)
        else $error("turn-off count passed its ceiling");
    AST_STATUS: assert property (@(posedge clk) disable iff (rst) // R13
        ovNow |=> statusVoutOv && hostAlertLineOe [*2])
        else $error("overvoltage status or alert missing");
    AST_MASK: assert property (@(posedge clk) disable iff (rst) // R15
        currentMode && !statusVoutOv && !statusVoutUv
        |=> !statusVoutOv && !statusVoutUv)
        else $error("status set in current mode");

endmodule : vofr_fault_response

// >>> tb/vofr_converter_model.sv
// Behavioural DC/DC converter seen by one supervised channel.
// Assumes the bench sets the running level; enable comes from the DUT.
`timescale 1ns/1ns
module vofr_converter_model
(
    input  wire logic        enable,       // Converter enable
    input  wire logic [15:0] target,       // Level while running
    output logic      [15:0] sampleVoltage // Supervisor reading
);
    // Output collapses to ground once the enable drops
    assign sampleVoltage = enable ? target : 16'h0000;
endmodule : vofr_converter_model

// >>> tb/tb.sv
// Self-checking bench for the fault response channel.
// Assumes the converter model closes the loop from enable to reading.
`timescale 1ns/1ns
module tb;
    localparam logic [15:0] NOM  = 16'h4000; // Healthy level
    localparam logic [15:0] HIGH = 16'h7000; // Above OV limit
    localparam logic [15:0] LOW  = 16'h1000; // Below UV limit
    logic        clk, rst, cfgWrite, cfgSelUv, sequencedOff;
    logic        channelOn, otherFault, currentMode;
    logic        faultClear, statusClear, channelEnable;
    logic        statusVoutOv, statusVoutUv, statusByteVout;
    logic        statusWordVout, hostAlertLineOut, hostAlertLineOe;
    logic [15:0] target, sampleVoltage, ovFaultLimit, uvFaultLimit;
    logic [7:0]  cfgData, ovResponseCfg, uvResponseCfg;
    logic [2:0]  retryLimit;       // Global retry count
    logic [20:0] toffDelay;        // Turn-off delay units
    int          error_cnt;        // Mismatches seen
    int          checks_done;      // Comparisons made
    int          cyc;              // Measured cycle count
    logic [7:0]  codes [3];        // Settings that shut down at once

    // Far side converter
    vofr_converter_model i_vofr_converter_model
        (.enable(channelEnable), .target, .sampleVoltage);

    // Channel under test
    vofr_fault_response i_vofr_fault_response
        (.clk, .rst, .sampleVoltage, .ovFaultLimit, .uvFaultLimit,
         .cfgWrite, .cfgSelUv, .cfgData, .retryLimit, .sequencedOff,
         .toffDelay, .channelOn, .otherFault, .currentMode, .faultClear,
         .statusClear, .ovResponseCfg, .uvResponseCfg, .channelEnable,
         .statusVoutOv, .statusVoutUv, .statusByteVout, .statusWordVout,
         .hostAlertLineOut, .hostAlertLineOe);

    // Compares one value, reports and counts a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // Accepts a measured count within a small jitter of the target
    task automatic near(input int seen, input int exp);
        check(32'(seen >= exp - 4 && seen <= exp + 4), 32'h1);
    endtask : near

    // Prints the counts and the verdict, then ends the run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // One-cycle setting write; readback is due right after
    task automatic put_cfg(input logic sel, input logic [7:0] d);
        @(posedge clk);
        cfgWrite <= 1'b1;
        cfgSelUv <= sel;
        cfgData  <= d;
        @(posedge clk);
        cfgWrite <= 1'b0;
        #1;
    endtask : put_cfg

    // Bounded wait for the enable level; counts cycles spent
    task automatic wait_en(input logic val, input int lim, output int n);
        n = 0;
        while (channelEnable !== val)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim)
            begin
                check(channelEnable, val);
                wrap_up();
            end
        end
    endtask : wait_en

    // Bounded wait for the summary status bit
    task automatic wait_stat();
        int t;
        t = 0;
        while (statusByteVout !== 1'b1)
        begin
            @(posedge clk);
            #1;
            t++;
            if (t > 1300)
            begin
                check(statusByteVout, 1'b1);
                wrap_up();
            end
        end
    endtask : wait_stat

    // Enable must hold one level for the whole span
    task automatic stay(input logic val, input int n);
        int bad;
        bad = 0;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            if (channelEnable !== val)
                bad++;
        end
        check(bad, 0);
    endtask : stay

    // Healthy level, clear pulses, channel back on and status empty
    task automatic finish_test(input string name);
        target <= NOM;
        @(posedge clk);
        faultClear  <= 1'b1;
        statusClear <= 1'b1;
        @(posedge clk);
        faultClear  <= 1'b0;
        statusClear <= 1'b0;
        wait_en(1'b1, 8, cyc);
        @(posedge clk);
        #1;
        check(statusByteVout, 1'b0);
        $display("test %s done", name);
    endtask : finish_test

    // Free-running core clock
    initial
    begin
        clk = 1'b0;
        forever
            #5 clk = ~clk;
    end

    // Main sequence
    initial
    begin
        rst = 1'b1;
        target = NOM;
        ovFaultLimit = 16'h6000;
        uvFaultLimit = 16'h0000;
        {cfgWrite, cfgSelUv, cfgData} = '0;
        retryLimit = 3'h0;
        sequencedOff = 1'b0;
        toffDelay = 21'h0;
        channelOn = 1'b1;
        {otherFault, currentMode, faultClear, statusClear} = '0;
        error_cnt = 0;
        checks_done = 0;
        codes = '{8'h80, 8'hc7, 8'h40};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check(ovResponseCfg, 8'h00);
        check(uvResponseCfg, 8'h00);
        put_cfg(1'b0, 8'ha5);
        put_cfg(1'b1, 8'h5a);
        check(ovResponseCfg, 8'ha5);
        check(uvResponseCfg, 8'h5a);
        put_cfg(1'b0, 8'h00);
        // Reading equal to the limit is not a fault
        target <= 16'h6000;
        stay(1'b1, 1300);
        check(statusByteVout, 1'b0);
        finish_test("settings");
        // Continue action still reports
        target <= HIGH;
        wait_stat();
        check({statusVoutOv, statusVoutUv}, 2'b10);
        check({statusByteVout, statusWordVout}, 2'b11);
        check({hostAlertLineOe, hostAlertLineOut}, 2'b10);
        stay(1'b1, 2500);
        finish_test("continue");
        // Shutdown with no wait, held off with retry zero
        foreach (codes[i])
        begin
            put_cfg(1'b0, codes[i]);
            target <= HIGH;
            wait_stat();
            wait_en(1'b0, 2, cyc);
            check(cyc, 0);
            stay(1'b0, 2500);
            finish_test("immediate");
        end
        // Deglitch of three samples, persistent then brief
        put_cfg(1'b0, 8'h43);
        target <= HIGH;
        wait_stat();
        wait_en(1'b0, 4000, cyc);
        near(cyc, 3 * vofr_pkg::SAMPLE_CYCLES);
        finish_test("deglitch");
        target <= HIGH;
        wait_stat();
        target <= NOM;
        stay(1'b1, 4000);
        finish_test("glitch");
        // Sequenced turn-off after two delay units
        put_cfg(1'b0, 8'h80);
        sequencedOff <= 1'b1;
        toffDelay <= 21'h2;
        target <= HIGH;
        wait_stat();
        wait_en(1'b0, 2100, cyc);
        near(cyc, 2 * vofr_pkg::TOFF_UNIT_CYCLES + 2);
        sequencedOff <= 1'b0;
        finish_test("sequenced");
        // Two restarts allowed, then held off
        put_cfg(1'b0, 8'h88);
        retryLimit <= 3'h2;
        target <= HIGH;
        repeat (2)
        begin
            wait_en(1'b0, 1300, cyc);
            wait_en(1'b1, 1300, cyc);
        end
        wait_en(1'b0, 1300, cyc);
        stay(1'b0, 3000);
        finish_test("retry");
        // Off command, then another fault, bar the restarts
        retryLimit <= 3'h7;
        for (int k = 0; k < 2; k++)
        begin
            target <= HIGH;
            wait_en(1'b0, 1300, cyc);
            channelOn  <= k[0];
            otherFault <= k[0];
            @(posedge clk);
            channelOn  <= 1'b1;
            otherFault <= 1'b0;
            stay(1'b0, 3000);
            finish_test("barred");
        end
        // Current mode masks detection
        currentMode <= 1'b1;
        target <= HIGH;
        stay(1'b1, 2600);
        check(statusByteVout, 1'b0);
        currentMode <= 1'b0;
        finish_test("current");
        // Undervoltage, first continue, then shutdown
        uvFaultLimit <= 16'h2000;
        put_cfg(1'b1, 8'h00);
        target <= LOW;
        wait_stat();
        check({statusVoutOv, statusVoutUv}, 2'b01);
        stay(1'b1, 1300);
        put_cfg(1'b1, 8'h80);
        wait_en(1'b0, 1300, cyc);
        check(channelEnable, 1'b0);
        uvFaultLimit <= 16'h0000;
        finish_test("undervoltage");
        wrap_up();
    end
endmodule : tb
